// ### shared/mgs_pkg.sv
// Constants, register map and frame helpers shared by both link ends.
// Assumes one 20 MHz clock and a byte-wide link that marks the last byte.
package mgs_pkg;
	localparam int          CLK_HZ         = 20_000_000;
	localparam int          RESP_WAIT_MS   = 10;
	localparam int          RESP_WAIT_CYC  = RESP_WAIT_MS * (CLK_HZ / 1000);
	localparam logic [7:0]  FC_READ        = 8'h03;
	localparam logic [7:0]  FC_WRITE_ONE   = 8'h06;
	localparam logic [7:0]  FC_WRITE_MULTI = 8'h10;
	localparam logic [15:0] RA_GROUP       = 16'h0030;
	localparam logic [15:0] RA_TRAVEL      = 16'h0400;
	localparam logic [15:0] RA_SPEED       = 16'h0480;
	localparam logic [15:0] RA_DRV_CMD     = 16'h007d;
	localparam int          DRV_START_BIT  = 3;
	localparam logic [31:0] GROUP_NONE     = 32'hffff_ffff;
	localparam logic [31:0] GROUP_MIN      = 32'h0000_0001;
	localparam logic [31:0] GROUP_MAX      = 32'h0000_001f;
	localparam logic [15:0] CRC_INIT       = 16'hffff;
	localparam logic [15:0] CRC_POLY       = 16'ha001;
	localparam logic [2:0]  HW_GRP_HI      = 3'h0;
	localparam logic [2:0]  HW_GRP_LO      = 3'h1;
	localparam logic [2:0]  HW_TRV_HI      = 3'h2;
	localparam logic [2:0]  HW_TRV_LO      = 3'h3;
	localparam logic [2:0]  HW_SPD_HI      = 3'h4;
	localparam logic [2:0]  HW_SPD_LO      = 3'h5;
	localparam logic [2:0]  HW_CMD         = 3'h6;
	localparam logic [2:0]  HW_NONE        = 3'h7;
	localparam int          HW_NUM         = 7;
	localparam logic [7:0]  IDX_ADDR       = 8'h00;
	localparam logic [7:0]  IDX_FC         = 8'h01;
	localparam logic [7:0]  IDX_RA_HI      = 8'h02;
	localparam logic [7:0]  IDX_RA_LO      = 8'h03;
	localparam logic [7:0]  IDX_CNT_HI     = 8'h04;
	localparam logic [7:0]  IDX_CNT_LO     = 8'h05;
	localparam logic [7:0]  IDX_BC         = 8'h06;
	localparam logic [7:0]  IDX_DATA       = 8'h07;
	localparam logic [7:0]  RD_DATA_IDX    = 8'h03;
	localparam logic [7:0]  HDR_LEN        = 8'h06;
	localparam logic [7:0]  LEN_SHORT      = 8'h08;
	localparam logic [7:0]  LEN_MULTI_FIX  = 8'h09;
	localparam logic [15:0] WR_MAX         = 16'h007b;
	localparam logic [15:0] WORD_REGS      = 16'h0002;
	localparam logic [7:0]  WORD_BYTES     = 8'h04;
	localparam logic [7:0]  CR_GO          = 8'h00;
	localparam logic [7:0]  CR_DEST        = 8'h04;
	localparam logic [7:0]  CR_FUNC        = 8'h08;
	localparam logic [7:0]  CR_REGADDR     = 8'h0c;
	localparam logic [7:0]  CR_VALUE       = 8'h10;
	localparam logic [7:0]  CR_STATUS      = 8'h14;
	localparam logic [7:0]  CR_RDATA       = 8'h18;
	localparam int          GO_BIT         = 0;

	function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	function automatic logic [2:0] hw_index(input logic [15:0] a);
		case (a)
			RA_GROUP:          return HW_GRP_HI;
			RA_GROUP + 16'h1:  return HW_GRP_LO;
			RA_TRAVEL:         return HW_TRV_HI;
			RA_TRAVEL + 16'h1: return HW_TRV_LO;
			RA_SPEED:          return HW_SPD_HI;
			RA_SPEED + 16'h1:  return HW_SPD_LO;
			RA_DRV_CMD:        return HW_CMD;
			default:           return HW_NONE;
		endcase
	endfunction
endpackage

// ### shared/mgs_link_if.sv
// Byte link between client and server, one byte per valid cycle.
// Assumes both ends share sys_clk; the last byte of a frame carries last.
interface mgs_link_if;
	logic       q_vld;
	logic [7:0] q_byte;
	logic       q_last;
	logic       r_vld;
	logic [7:0] r_byte;
	logic       r_last;
	modport server (input q_vld, input q_byte, input q_last,
		output r_vld, output r_byte, output r_last);
	modport client (output q_vld, output q_byte, output q_last,
		input r_vld, input r_byte, input r_last);
endinterface

// ### core/mgs_crc16.sv
// Running frame check over a byte stream, cleared between frames.
// Assumes en and clr come from logic on sys_clk.
module mgs_crc16 (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        clr,
	input  wire logic        en,
	input  wire logic [7:0]  din,
	output logic      [15:0] crc,
	output logic      [15:0] crc_nxt
);
	import mgs_pkg::*;

	always_comb begin
		crc_nxt = en ? crc16_byte(crc, din) : crc;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn || clr) begin
			crc <= CRC_INIT;
		end else begin
			crc <= crc_nxt;
		end
	end
endmodule

// ### core/mgs_server.sv
// Server end: parses queries, executes writes and reads, answers as parent.
// Assumes a half-duplex link; bytes arriving while answering are dropped.
// Operation
// (R1) Only parent answers; group children stay silent
// (R2) Child executes queries sent to its group
// (R3) Parent uses own address, no setup
// (R4) Parent executes first, then answers normally
// (R5) Group holds -1 or 1..31 at 0030h
// (R6) Client changes group only by unicast
// (R7) Client accesses both group halves together
// (R8) Group is volatile, resets to no group
// (R9) Group send uses function code 10h
// (R10) Multi-write: addr, fc, start, count, bytes
// (R11) 32-bit value: upper register first, big-endian
// (R12) Every frame ends in CRC, low first
// (R13) Travel amount entry 0 at 0400h
// (R14) Run speed entry 0 at 0480h
// (R15) Write answer echoes header plus fresh CRC
// (R16) Command 007Dh bit 3 drives start
//
// Local design decision: the plain strobed port.
module mgs_server #(
	parameter int RD_MAX = 8
) (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	mgs_link_if.server       link,
	input  wire logic [7:0]  own_addr,
	output logic      [31:0] group_addr,
	output logic      [31:0] travel_amount,
	output logic      [31:0] run_speed,
	output logic             start_cmd,
	output logic             exec_pulse
);
	import mgs_pkg::*;

	typedef enum logic [1:0] {S_RX, S_BODY, S_CRC_LO, S_CRC_HI} mgs_srv_st_t;

	generate
		if (RD_MAX < 1 || RD_MAX > 120) begin : g_chk
			$error("RD_MAX must be 1 to 120");
		end
	endgenerate

	mgs_srv_st_t       st_r;
	logic [7:0]        idx_r;
	logic [7:0]        hi_r;
	logic [7:0]        bc_r;
	logic [7:0]        tx_j_r;
	logic [7:0]        tx_len_r;
	logic              is_read_r;
	logic              bad_r;
	logic              exec_r;
	logic              r_vld_r;
	logic              r_last_r;
	logic [7:0]        r_byte_r;
	logic [7:0]        hdr_r [0:5];
	logic [15:0]       hw_r [0:HW_NUM-1];
	logic [15:0]       sh_r [0:HW_NUM-1];
	logic [HW_NUM-1:0] pend_r;
	logic [15:0]       rx_crc;
	logic [15:0]       rx_crc_nxt;
	logic [15:0]       tx_crc;
	logic              rx;
	logic              eof;
	logic              st_en;
	logic [2:0]        st_ix;
	logic [15:0]       st_val;
	logic [7:0]        off;
	logic [7:0]        fl;
	logic [7:0]        fc;
	logic [15:0]       ra;
	logic [15:0]       cnt;
	logic [31:0]       grp;
	logic [31:0]       cand;
	logic              hit;
	logic              len_ok;
	logic              grp_ok;
	logic              good;
	logic              reply;
	logic [7:0]        k;
	logic [15:0]       rdv;
	logic [7:0]        tx_byte;

	function automatic logic [15:0] hw_rd(input logic [15:0] a);
		logic [2:0] i;
		i = hw_index(a);
		return (i == HW_NONE) ? 16'h0000 : hw_r[i];
	endfunction

	assign rx  = (st_r == S_RX) && link.q_vld;
	assign eof = rx && link.q_last;
	assign fc  = hdr_r[IDX_FC[2:0]];
	assign ra  = {hdr_r[IDX_RA_HI[2:0]], hdr_r[IDX_RA_LO[2:0]]};
	assign cnt = {hdr_r[IDX_CNT_HI[2:0]], hdr_r[IDX_CNT_LO[2:0]]};
	assign grp = {hw_r[HW_GRP_HI], hw_r[HW_GRP_LO]};
	assign off = idx_r - IDX_DATA;
	assign fl  = idx_r + 8'h01;

	mgs_crc16 u_rx_crc (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.clr     (eof),
		.en      (rx),
		.din     (link.q_byte),
		.crc     (rx_crc),
		.crc_nxt (rx_crc_nxt)
	);

	// Stage incoming register data; nothing lands before the CRC is seen
	always_comb begin
		st_en  = 1'b0;
		st_ix  = HW_NONE;
		st_val = 16'h0000;
		if (rx && fc == FC_WRITE_ONE && idx_r == IDX_CNT_LO) begin
			st_en  = 1'b1;
			st_ix  = hw_index(ra);
			st_val = {hdr_r[IDX_CNT_HI[2:0]], link.q_byte}; // R16
		end else if (rx && fc == FC_WRITE_MULTI && idx_r >= IDX_DATA && off < bc_r && off[0]) begin
			st_en  = 1'b1;
			st_ix  = hw_index(ra + {9'h000, off[7:1]}); // R11 R13 R14
			st_val = {hi_r, link.q_byte}; // R11
		end
	end

	always_comb begin
		cand   = {pend_r[HW_GRP_HI] ? sh_r[HW_GRP_HI] : hw_r[HW_GRP_HI],
		          pend_r[HW_GRP_LO] ? sh_r[HW_GRP_LO] : hw_r[HW_GRP_LO]};
		grp_ok = (cand == GROUP_NONE) || (cand >= GROUP_MIN && cand <= GROUP_MAX); // R5
		hit    = (hdr_r[IDX_ADDR[2:0]] == own_addr) // R3
		      || (grp != GROUP_NONE && hdr_r[IDX_ADDR[2:0]] == grp[7:0]); // R2
		case (fc)
			FC_READ:        len_ok = fl == LEN_SHORT && cnt != 16'h0 && cnt <= 16'(RD_MAX);
			FC_WRITE_ONE:   len_ok = fl == LEN_SHORT;
			FC_WRITE_MULTI: len_ok = cnt != 16'h0 && cnt <= WR_MAX && {cnt[6:0], 1'b0} == bc_r
			                      && fl == LEN_MULTI_FIX + bc_r; // R9 R10
			default:        len_ok = 1'b0;
		endcase
		good  = eof && rx_crc_nxt == 16'h0000 && hit && len_ok && grp_ok && !bad_r; // R12
		reply = good && hdr_r[IDX_ADDR[2:0]] == own_addr; // R1
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn || eof) begin
			idx_r <= 8'h00;
		end else if (rx && idx_r != 8'hff) begin
			idx_r <= idx_r + 8'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			for (int i = 0; i < int'(HDR_LEN); i++) begin
				hdr_r[i] <= 8'h00;
			end
			bc_r <= 8'h00;
			hi_r <= 8'h00;
		end else if (rx) begin
			if (idx_r < HDR_LEN) begin
				hdr_r[idx_r[2:0]] <= link.q_byte; // R10
			end
			if (idx_r == IDX_BC) begin
				bc_r <= link.q_byte;
			end
			if (!off[0]) begin
				hi_r <= link.q_byte;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn || eof) begin
			pend_r <= '0;
			bad_r  <= 1'b0;
		end else if (st_en) begin
			if (st_ix == HW_NONE) begin
				bad_r <= 1'b1;
			end else begin
				pend_r[st_ix] <= 1'b1;
				sh_r[st_ix]   <= st_val;
			end
		end
	end

	// Live registers; no path to any non-volatile store exists
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			for (int i = 0; i < HW_NUM; i++) begin
				hw_r[i] <= (i <= int'(HW_GRP_LO)) ? GROUP_NONE[15:0] : 16'h0000; // R8
			end
		end else if (good && fc != FC_READ) begin
			for (int i = 0; i < HW_NUM; i++) begin
				if (pend_r[i]) begin
					hw_r[i] <= sh_r[i]; // R4
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			exec_r <= 1'b0;
		end else begin
			exec_r <= good;
		end
	end

	always_comb begin
		k   = tx_j_r - RD_DATA_IDX;
		rdv = hw_rd(ra + {9'h000, k[7:1]});
		if (!is_read_r) begin
			tx_byte = hdr_r[tx_j_r[2:0]]; // R15
		end else if (tx_j_r < RD_DATA_IDX) begin
			tx_byte = (tx_j_r == IDX_RA_HI) ? {cnt[6:0], 1'b0} : hdr_r[tx_j_r[2:0]];
		end else begin
			tx_byte = k[0] ? rdv[7:0] : rdv[15:8]; // R11
		end
	end

	mgs_crc16 u_tx_crc (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.clr     (st_r == S_RX),
		.en      (st_r == S_BODY),
		.din     (tx_byte),
		.crc     (tx_crc),
		.crc_nxt ()
	);

	// Answer states start the cycle after the commit edge; its first byte reaches the link one cycle later
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			st_r      <= S_RX;
			tx_j_r    <= 8'h00;
			tx_len_r  <= HDR_LEN;
			is_read_r <= 1'b0;
		end else begin
			unique case (st_r)
				S_RX: begin
					if (reply) begin
						st_r      <= S_BODY; // R4
						tx_j_r    <= 8'h00;
						is_read_r <= fc == FC_READ;
						tx_len_r  <= (fc == FC_READ) ? RD_DATA_IDX + {cnt[6:0], 1'b0} : HDR_LEN;
					end
				end
				S_BODY: begin
					tx_j_r <= tx_j_r + 8'h01;
					if (tx_j_r == tx_len_r - 8'h01) begin
						st_r <= S_CRC_LO;
					end
				end
				S_CRC_LO: st_r <= S_CRC_HI;
				S_CRC_HI: st_r <= S_RX;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			r_vld_r  <= 1'b0;
			r_byte_r <= 8'h00;
			r_last_r <= 1'b0;
		end else begin
			r_vld_r  <= st_r != S_RX;
			r_last_r <= st_r == S_CRC_HI;
			unique case (st_r)
				S_BODY:   r_byte_r <= tx_byte;
				S_CRC_LO: r_byte_r <= tx_crc[7:0]; // R12
				S_CRC_HI: r_byte_r <= tx_crc[15:8];
				S_RX:     r_byte_r <= 8'h00;
			endcase
		end
	end

	assign link.r_vld    = r_vld_r;
	assign link.r_byte   = r_byte_r;
	assign link.r_last   = r_last_r;
	assign group_addr    = grp;
	assign travel_amount = {hw_r[HW_TRV_HI], hw_r[HW_TRV_LO]};
	assign run_speed     = {hw_r[HW_SPD_HI], hw_r[HW_SPD_LO]};
	assign start_cmd     = hw_r[HW_CMD][DRV_START_BIT]; // R16
	assign exec_pulse    = exec_r;
endmodule

// ### core/mgs_client.sv
// Client end: builds one query on software order and checks the answer.
// Assumes software polls status; a silent child ends in a no-reply timeout.
module mgs_client #(
	parameter int WAIT_CYC = mgs_pkg::RESP_WAIT_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	mgs_link_if.client       link,
	input  wire logic [7:0]  cpu_addr,
	input  wire logic [31:0] cpu_wdata,
	input  wire logic        cpu_wr,
	input  wire logic        cpu_rd,
	output logic      [31:0] cpu_rdata
);
	import mgs_pkg::*;

	typedef enum logic [2:0] {C_IDLE, C_BODY, C_CRC_LO, C_CRC_HI, C_WAIT} mgs_cli_st_t;

	generate
		if (WAIT_CYC < 1) begin : g_chk
			$error("WAIT_CYC must be positive");
		end
	endgenerate

	mgs_cli_st_t st_r;
	logic [7:0]  dest_r;
	logic [7:0]  func_r;
	logic [15:0] ra_r;
	logic [31:0] val_r;
	logic [31:0] rdata_r;
	logic [31:0] rd_r;
	logic [31:0] wait_r;
	logic [7:0]  j_r;
	logic [7:0]  ridx_r;
	logic [7:0]  raddr_r;
	logic [7:0]  rfc_r;
	logic        done_r;
	logic        ok_r;
	logic        noreply_r;
	logic        q_vld_r;
	logic        q_last_r;
	logic [7:0]  q_byte_r;
	logic [7:0]  body;
	logic [7:0]  body_len;
	logic [15:0] tx_crc;
	logic [15:0] rx_crc;
	logic [15:0] rx_crc_nxt;
	logic        rx;
	logic        go;

	assign rx = (st_r == C_WAIT) && link.r_vld;
	assign go = cpu_wr && cpu_addr == CR_GO && cpu_wdata[GO_BIT] && st_r == C_IDLE;

	// One destination per query, so group changes go out unicast
	always_comb begin
		body_len = (func_r == FC_WRITE_MULTI) ? IDX_DATA + WORD_BYTES : HDR_LEN;
		case (j_r)
			IDX_ADDR:   body = dest_r; // R6
			IDX_FC:     body = func_r; // R9
			IDX_RA_HI:  body = ra_r[15:8];
			IDX_RA_LO:  body = ra_r[7:0];
			IDX_CNT_HI: body = (func_r == FC_WRITE_ONE) ? val_r[15:8] : WORD_REGS[15:8];
			IDX_CNT_LO: body = (func_r == FC_WRITE_ONE) ? val_r[7:0] : WORD_REGS[7:0]; // R7
			IDX_BC:     body = WORD_BYTES; // R10
			IDX_DATA:   body = val_r[31:24]; // R11
			IDX_DATA + 8'h01: body = val_r[23:16];
			IDX_DATA + 8'h02: body = val_r[15:8];
			IDX_DATA + 8'h03: body = val_r[7:0];
			default:    body = 8'h00;
		endcase
	end

	mgs_crc16 u_tx_crc (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.clr     (st_r == C_IDLE),
		.en      (st_r == C_BODY),
		.din     (body),
		.crc     (tx_crc),
		.crc_nxt ()
	);

	mgs_crc16 u_rx_crc (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.clr     (st_r != C_WAIT),
		.en      (rx),
		.din     (link.r_byte),
		.crc     (rx_crc),
		.crc_nxt (rx_crc_nxt)
	);

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			dest_r <= 8'h00;
			func_r <= FC_WRITE_MULTI;
			ra_r   <= 16'h0000;
			val_r  <= 32'h0000_0000;
		end else if (cpu_wr && st_r == C_IDLE) begin
			case (cpu_addr)
				CR_DEST:    dest_r <= cpu_wdata[7:0];
				CR_FUNC:    func_r <= cpu_wdata[7:0];
				CR_REGADDR: ra_r   <= cpu_wdata[15:0];
				CR_VALUE:   val_r  <= cpu_wdata;
				default:    ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			st_r      <= C_IDLE;
			j_r       <= 8'h00;
			wait_r    <= 32'h0;
			done_r    <= 1'b0;
			ok_r      <= 1'b0;
			noreply_r <= 1'b0;
		end else begin
			unique case (st_r)
				C_IDLE: begin
					if (go) begin
						st_r      <= C_BODY;
						j_r       <= 8'h00;
						done_r    <= 1'b0;
						ok_r      <= 1'b0;
						noreply_r <= 1'b0;
					end
				end
				C_BODY: begin
					j_r <= j_r + 8'h01;
					if (j_r == body_len - 8'h01) begin
						st_r <= C_CRC_LO;
					end
				end
				C_CRC_LO: st_r <= C_CRC_HI;
				C_CRC_HI: begin
					st_r   <= C_WAIT;
					wait_r <= 32'h0;
				end
				C_WAIT: begin
					wait_r <= wait_r + 32'h1;
					if (rx && link.r_last) begin
						st_r   <= C_IDLE;
						done_r <= 1'b1;
						ok_r   <= rx_crc_nxt == 16'h0000 && raddr_r == dest_r
						       && rfc_r == func_r; // R12 R15
					end else if (wait_r == 32'(WAIT_CYC - 1)) begin
						st_r      <= C_IDLE;
						done_r    <= 1'b1;
						noreply_r <= 1'b1; // R1
					end
				end
				default: st_r <= C_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn || st_r != C_WAIT) begin
			ridx_r <= 8'h00;
		end else if (rx && ridx_r != 8'hff) begin
			ridx_r <= ridx_r + 8'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			raddr_r <= 8'h00;
			rfc_r   <= 8'h00;
			rdata_r <= 32'h0;
		end else if (rx) begin
			if (ridx_r == IDX_ADDR) begin
				raddr_r <= link.r_byte;
			end
			if (ridx_r == IDX_FC) begin
				rfc_r <= link.r_byte;
			end
			if (ridx_r >= RD_DATA_IDX && ridx_r < RD_DATA_IDX + WORD_BYTES) begin
				rdata_r <= {rdata_r[23:0], link.r_byte}; // R11
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			q_vld_r  <= 1'b0;
			q_last_r <= 1'b0;
			q_byte_r <= 8'h00;
		end else begin
			q_vld_r  <= st_r == C_BODY || st_r == C_CRC_LO || st_r == C_CRC_HI;
			q_last_r <= st_r == C_CRC_HI;
			case (st_r)
				C_BODY:   q_byte_r <= body;
				C_CRC_LO: q_byte_r <= tx_crc[7:0]; // R12
				C_CRC_HI: q_byte_r <= tx_crc[15:8];
				default:  q_byte_r <= 8'h00;
			endcase
		end
	end

	// Read data only in the cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (!resetn || !cpu_rd) begin
			rd_r <= 32'h0;
		end else begin
			case (cpu_addr)
				CR_DEST:    rd_r <= {24'h0, dest_r};
				CR_FUNC:    rd_r <= {24'h0, func_r};
				CR_REGADDR: rd_r <= {16'h0, ra_r};
				CR_VALUE:   rd_r <= val_r;
				CR_STATUS:  rd_r <= {28'h0, noreply_r, ok_r, done_r, st_r != C_IDLE};
				CR_RDATA:   rd_r <= rdata_r;
				default:    rd_r <= 32'h0;
			endcase
		end
	end

	assign link.q_vld  = q_vld_r;
	assign link.q_byte = q_byte_r;
	assign link.q_last = q_last_r;
	assign cpu_rdata   = rd_r;
endmodule

// ### dv/mgs_link_checker.sv
// Protocol checks on the client/parent byte link.
// Assumes one clock and that the link signals come straight from the interface.
module mgs_link_checker (
	input wire logic       sys_clk,
	input wire logic       resetn,
	input wire logic       q_vld,
	input wire logic [7:0] q_byte,
	input wire logic       q_last,
	input wire logic       r_vld,
	input wire logic [7:0] r_byte,
	input wire logic       r_last
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0]  q_cnt_r;
	logic [7:0]  r_cnt_r;
	logic [15:0] qcrc_r;
	logic [15:0] rcrc_r;
	logic [7:0]  qb_r [7];

	// Own copy of the check step, kept apart from the design's helper
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
		return r;
	endfunction

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			q_cnt_r <= 8'h00;
			qcrc_r  <= 16'hffff;
		end else if (q_vld) begin
			q_cnt_r <= q_last ? 8'h00 : q_cnt_r + 8'h01;
			qcrc_r  <= q_last ? 16'hffff : crc_step(qcrc_r, q_byte);
			if (q_cnt_r < 8'h07) qb_r[q_cnt_r[2:0]] <= q_byte;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			r_cnt_r <= 8'h00;
			rcrc_r  <= 16'hffff;
		end else if (r_vld) begin
			r_cnt_r <= r_last ? 8'h00 : r_cnt_r + 8'h01;
			rcrc_r  <= r_last ? 16'hffff : crc_step(rcrc_r, r_byte);
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	AST_Q_CRC: assert property (q_vld && q_last |-> crc_step(qcrc_r, q_byte) == 16'h0000)
		else $error("query check value wrong");
	AST_R_CRC: assert property (r_vld && r_last |-> crc_step(rcrc_r, r_byte) == 16'h0000)
		else $error("answer check value wrong");
	AST_BYTE_COUNT: assert property (q_vld && q_cnt_r == 8'h06 && qb_r[1] == 8'h10
		|-> q_byte == {qb_r[5][6:0], 1'b0}) else $error("byte count not twice count");
	AST_ECHO_HEAD: assert property (r_vld && r_cnt_r < 8'h02
		|-> r_byte == qb_r[r_cnt_r[2:0]]) else $error("answer head differs");
	AST_ECHO_WRITE: assert property (r_vld && r_cnt_r < 8'h06 && qb_r[1] != 8'h03
		|-> r_byte == qb_r[r_cnt_r[2:0]]) else $error("write answer not echoed");
	AST_WRITE_LEN: assert property (r_vld && r_last && qb_r[1] != 8'h03
		|-> r_cnt_r == 8'h07) else $error("write answer length wrong");
	AST_RESP_START: assert property ($rose(r_vld) |-> $past(q_last, 2))
		else $error("answer start not two cycles after query end");
	AST_NO_GAP: assert property (r_vld && !r_last |=> r_vld)
		else $error("gap inside answer");
	AST_ANSWER_END: assert property (r_vld && r_last |=> !r_vld [*2])
		else $error("answer runs past last byte");
	AST_LAST_VALID: assert property (r_last |-> r_vld)
		else $error("last without valid");
endmodule

// ### dv/testbench.sv
// Bench: client, parent server and a child server sharing the query wires.
// Assumes the child answers only on its own link, which the client never hears.
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import mgs_pkg::*;
	logic        sys_clk   = 1'b0;
	logic        resetn    = 1'b0;
	logic [7:0]  cpu_addr  = 8'h00;
	logic [31:0] cpu_wdata = 32'h0;
	logic        cpu_wr    = 1'b0;
	logic        cpu_rd    = 1'b0;
	logic [31:0] cpu_rdata;
	logic [31:0] p_grp, p_trv, p_spd, c_grp, c_trv;
	logic        p_start;
	logic        p_exec, c_exec;
	int          p_exec_n = 0;
	int          c_exec_n = 0;
	logic [63:0] rsh;
	logic [15:0] qsh;
	logic [31:0] s, d;
	int          bad_count = 0;
	int          n_compared = 0;
	int          child_cnt = 0;
	int          k;

	always #25 sys_clk = ~sys_clk;

	mgs_link_if link();
	mgs_link_if link_c();
	// Child hears every query but answers on a wire of its own
	assign link_c.q_vld  = link.q_vld;
	assign link_c.q_byte = link.q_byte;
	assign link_c.q_last = link.q_last;

	mgs_client #(.WAIT_CYC(200)) mgs_client_i (.sys_clk(sys_clk), .resetn(resetn),
		.link(link), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
		.cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata));
	mgs_server mgs_server_i (.sys_clk(sys_clk), .resetn(resetn), .link(link),
		.own_addr(8'h01), .group_addr(p_grp), .travel_amount(p_trv), .run_speed(p_spd),
		.start_cmd(p_start), .exec_pulse(p_exec));
	mgs_server mgs_server_child_i (.sys_clk(sys_clk), .resetn(resetn), .link(link_c),
		.own_addr(8'h02), .group_addr(c_grp), .travel_amount(c_trv), .run_speed(),
		.start_cmd(), .exec_pulse(c_exec));
	mgs_link_checker mgs_link_checker_i (.sys_clk(sys_clk), .resetn(resetn),
		.q_vld(link.q_vld), .q_byte(link.q_byte), .q_last(link.q_last),
		.r_vld(link.r_vld), .r_byte(link.r_byte), .r_last(link.r_last));

	always @(posedge sys_clk) begin
		if (link.r_vld) rsh <= {rsh[55:0], link.r_byte};
		if (link.q_vld) qsh <= {qsh[7:0], link.q_byte};
		if (link_c.r_vld) child_cnt <= child_cnt + 1;
		if (p_exec) p_exec_n <= p_exec_n + 1;
		if (c_exec) c_exec_n <= c_exec_n + 1;
	end

	task automatic stop_test();
		if (bad_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		cpu_addr  <= a;
		cpu_wdata <= v;
		cpu_wr    <= 1'b1;
		@(posedge sys_clk);
		cpu_wr <= 1'b0;
	endtask

	// Data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		cpu_addr <= a;
		cpu_rd   <= 1'b1;
		@(posedge sys_clk);
		cpu_rd <= 1'b0;
		#1 v = cpu_rdata;
	endtask

	// st = {no reply, answer ok}
	task automatic query(input logic [7:0] dst, input logic [7:0] fc, input logic [15:0] ra,
		input logic [31:0] v, input logic [1:0] st);
		int i;
		wr(CR_DEST, {24'h0, dst});
		wr(CR_FUNC, {24'h0, fc});
		wr(CR_REGADDR, {16'h0, ra});
		wr(CR_VALUE, v);
		wr(CR_GO, 32'h1);
		for (i = 0; i < 400; i++) begin
			rd(CR_STATUS, s);
			if (s[0] === 1'b0) break;
		end
		if (i == 400) begin
			bad_count++;
			stop_test();
		end
		`CHK(s[3:2], st)
	endtask

	initial begin
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		`CHK(p_grp, GROUP_NONE)
		`CHK(c_grp, GROUP_NONE)
		query(8'h01, FC_WRITE_MULTI, RA_TRAVEL, 32'h0000_03e8, 2'b01);
		`CHK(qsh, 16'hc1d1)
		`CHK(p_trv, 32'h0000_03e8)
		query(8'h01, FC_WRITE_MULTI, RA_SPEED, 32'h0000_1388, 2'b01);
		`CHK(rsh, 64'h0110_0480_0002_4110)
		`CHK(p_spd, 32'h0000_1388)
		query(8'h01, FC_WRITE_ONE, RA_DRV_CMD, 32'h0000_0008, 2'b01);
		`CHK(rsh, 64'h0106_007d_0008_1814)
		`CHK(p_start, 1'b1)
		query(8'h01, FC_WRITE_ONE, RA_DRV_CMD, 32'h0000_0000, 2'b01);
		`CHK(qsh, 16'h19d2)
		`CHK(p_start, 1'b0)
		// Unicast group change: the answer goes out on the child's own link
		query(8'h02, FC_WRITE_MULTI, RA_GROUP, 32'h0000_0001, 2'b10);
		`CHK(c_grp, 32'h0000_0001)
		k = child_cnt;
		query(8'h01, FC_WRITE_MULTI, RA_TRAVEL, 32'h0000_07d0, 2'b01);
		`CHK(p_trv, 32'h0000_07d0)
		`CHK(c_trv, 32'h0000_07d0)
		`CHK(child_cnt, k)
		query(8'h02, FC_WRITE_MULTI, RA_GROUP, 32'h0000_0020, 2'b10);
		`CHK(c_grp, 32'h0000_0001)
		`CHK(c_exec_n, 2)
		query(8'h02, FC_WRITE_MULTI, RA_GROUP, GROUP_NONE, 2'b10);
		`CHK(c_grp, GROUP_NONE)
		query(8'h01, FC_WRITE_MULTI, RA_TRAVEL, 32'h0000_0064, 2'b01);
		`CHK(c_trv, 32'h0000_07d0)
		`CHK(p_trv, 32'h0000_0064)
		`CHK(c_exec_n, 3)
		query(8'h01, FC_READ, RA_TRAVEL, 32'h0, 2'b01);
		rd(CR_RDATA, d);
		`CHK(d, 32'h0000_0064)
		rd(8'hfc, d);
		`CHK(d, 32'h0)
		`CHK(p_exec_n, 7)
		stop_test();
	end
endmodule
